// ===== hw/system_clock_reset_wake_control.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module system_clock_reset_wake_control
  import clk_rst_wake_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic external_reset_pin_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  input wire logic wake_frame_event,
  input wire logic energy_detect_event,
  input wire logic magic_packet_event,
  input wire logic loader_done,
  output logic loader_run,
  output logic wake_event_output,
  output logic ref_tick,
  output logic digital_reset_n,
  output logic host_group_reset_n,
  output logic port1_phy_reset_n,
  output logic port2_phy_reset_n,
  output logic virtual_phy_reset_n,
  output logic port1_power_down,
  output logic port1_energy_detect_pd,
  output logic port2_power_down,
  output logic port2_energy_detect_pd
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] reset_control_reg;
    logic host_group_reset_bit;
    logic [15:0] power_mgmt_control_reg;
    logic [1:0] port_phy_reset;
    logic [1:0] port_phy_pd;
    logic virtual_phy_reset;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [15:0] gpt_reload;
    logic [15:0] gpt_count;
    logic gpt_en;
    logic [31:0] free_count;
    logic reload_cmd;
    logic load_run;
    logic load_pending;
    logic [DATA_W-1:0] read_word;
    logic irq_out;
    logic wake_out;
    logic [3:0] power;
  } ctl_state_type;

  // Loader pending from reset, so it runs after power-on and pin reset
  localparam ctl_state_type INIT = '{
    power_mgmt_control_reg: PMT_RESET,
    gpt_reload: GPT_RELOAD_RESET,
    gpt_count: GPT_RELOAD_RESET,
    load_pending: 1'b1,
    default: '0
  };

  ctl_state_type st;
  ctl_state_type next_st;

  logic pin_reset;
  logic timer_tick;
  logic ref_strobe;
  logic [DOM_N-1:0] dom_req;
  logic [DOM_N-1:0] dom_rst_n;
  logic [DOM_N-1:0] dom_active;
  logic [DOM_N-1:0] dom_done;

  assign pin_reset = !external_reset_pin_n;

  // ----------------------------------------
  // Clock divisions
  // ----------------------------------------
  ref_clock_divider #(
    .REF_DIVIDE(REF_DIV),
    .TICK_DIVIDE(GPT_TICK_DIV)
  ) u_divider (
    .mclk(mclk),
    .reset_n(reset_n),
    .ref_tick(ref_strobe),
    .timer_tick(timer_tick)
  );

  // ----------------------------------------
  // Reset domains
  // ----------------------------------------
  always_comb begin
    dom_req[DOM_DIGITAL] = st.reset_control_reg[DIGITAL_BIT];
    // Digital reset covers the host group as well
    dom_req[DOM_HOST] = st.host_group_reset_bit
      | st.reset_control_reg[DIGITAL_BIT];
    dom_req[DOM_PORT1] = st.reset_control_reg[PORT1_PHY_BIT]
      | st.port_phy_reset[0];
    dom_req[DOM_PORT2] = st.reset_control_reg[PORT2_PHY_BIT]
      | st.port_phy_reset[1];
    dom_req[DOM_VPHY] = st.reset_control_reg[DIGITAL_BIT]
      | st.power_mgmt_control_reg[PMT_VPHY_RESET_BIT]
      | st.virtual_phy_reset;
  end

  // Pin reset holds every domain, PHYs included
  genvar gi;
  generate
    for (gi = 0; gi < DOM_N; gi++) begin : g_dom
      reset_domain_pulse #(
        .CYCLES(RESET_CYCLES)
      ) u_pulse (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(dom_req[gi]),
        .hold(pin_reset),
        .domain_reset_n(dom_rst_n[gi]),
        .active(dom_active[gi]),
        .done(dom_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] events;
    events = '0;
    next_st = st;

    // Hardware clears first so a same-cycle software set wins
    if (dom_done[DOM_DIGITAL]) begin
      next_st.reset_control_reg[DIGITAL_BIT] = 1'b0;
      next_st.load_pending = 1'b1;
    end
    if (dom_done[DOM_HOST]) begin
      next_st.host_group_reset_bit = 1'b0;
    end
    if (dom_done[DOM_PORT1]) begin
      next_st.reset_control_reg[PORT1_PHY_BIT] = 1'b0;
      next_st.port_phy_reset[0] = 1'b0;
    end
    if (dom_done[DOM_PORT2]) begin
      next_st.reset_control_reg[PORT2_PHY_BIT] = 1'b0;
      next_st.port_phy_reset[1] = 1'b0;
    end
    if (dom_done[DOM_VPHY]) begin
      next_st.power_mgmt_control_reg[PMT_VPHY_RESET_BIT] = 1'b0;
      next_st.virtual_phy_reset = 1'b0;
    end

    // Loader waits until no domain is still in reset
    if (st.load_run) begin
      if (loader_done) begin
        next_st.load_run = 1'b0;
        next_st.reload_cmd = 1'b0;
        events[IRQ_LOADER] = 1'b1;
      end
    end else if ((st.load_pending || st.reload_cmd) && !(|dom_active)) begin
      next_st.load_run = 1'b1;
      next_st.load_pending = 1'b0;
    end

    // Timer counts down at the prescaled rate and reloads at zero
    if (st.gpt_en && timer_tick) begin
      if (st.gpt_count == 16'h0000) begin
        next_st.gpt_count = st.gpt_reload;
        events[IRQ_GPT] = 1'b1;
      end else begin
        next_st.gpt_count = st.gpt_count - 16'h0001;
      end
    end
    if (ref_strobe) begin
      next_st.free_count = st.free_count + 32'h0000_0001;
    end

    events[IRQ_WAKE_FRAME] = wake_frame_event;
    events[IRQ_ENERGY] = energy_detect_event;
    events[IRQ_MAGIC] = magic_packet_event;

    if (wr) begin
      case (addr)
        REG_RESET_CTRL: begin
          next_st.reset_control_reg = next_st.reset_control_reg
            | wdata[PORT2_PHY_BIT:DIGITAL_BIT];
        end
        REG_HW_CONFIG: begin
          next_st.host_group_reset_bit = next_st.host_group_reset_bit
            | wdata[HOST_GROUP_BIT];
        end
        REG_PMT_CTL: begin
          // Reset bit only sets; writing zero leaves a pending reset
          next_st.power_mgmt_control_reg = wdata[15:0];
          next_st.power_mgmt_control_reg[PMT_VPHY_RESET_BIT] =
            st.power_mgmt_control_reg[PMT_VPHY_RESET_BIT]
            & !dom_done[DOM_VPHY]
            | wdata[PMT_VPHY_RESET_BIT];
        end
        REG_P1_BASIC: begin
          next_st.port_phy_reset[0] = next_st.port_phy_reset[0]
            | wdata[PHY_RESET_BIT];
          next_st.port_phy_pd[0] = wdata[PHY_POWER_DOWN_BIT];
        end
        REG_P2_BASIC: begin
          next_st.port_phy_reset[1] = next_st.port_phy_reset[1]
            | wdata[PHY_RESET_BIT];
          next_st.port_phy_pd[1] = wdata[PHY_POWER_DOWN_BIT];
        end
        REG_VPHY_BASIC: begin
          next_st.virtual_phy_reset = next_st.virtual_phy_reset
            | wdata[PHY_RESET_BIT];
        end
        REG_INT_STS: begin
          next_st.status = st.status & ~wdata[IRQ_W-1:0];
        end
        REG_INT_MASK: begin
          next_st.mask = wdata[IRQ_W-1:0];
        end
        REG_GPT_CFG: begin
          next_st.gpt_reload = wdata[15:0];
          next_st.gpt_count = wdata[15:0];
          next_st.gpt_en = wdata[GPT_EN_BIT];
        end
        REG_LOADER_CMD: begin
          next_st.reload_cmd = next_st.reload_cmd | wdata[LOADER_RELOAD_BIT];
        end
        default: begin
        end
      endcase
    end
    next_st.status = next_st.status | events;

    // Host group state held cleared while its domain is in reset
    if (dom_active[DOM_HOST]) begin
      next_st.status = '0;
      next_st.mask = '0;
      next_st.gpt_en = 1'b0;
      next_st.gpt_reload = GPT_RELOAD_RESET;
      next_st.gpt_count = GPT_RELOAD_RESET;
    end

    next_st.read_word = '0;
    if (rd) begin
      case (addr)
        REG_RESET_CTRL: next_st.read_word[2:0] = st.reset_control_reg;
        REG_HW_CONFIG: begin
          next_st.read_word[HOST_GROUP_BIT] = st.host_group_reset_bit;
        end
        REG_PMT_CTL: next_st.read_word[15:0] = st.power_mgmt_control_reg;
        REG_P1_BASIC: begin
          next_st.read_word[PHY_RESET_BIT] = st.port_phy_reset[0];
          next_st.read_word[PHY_POWER_DOWN_BIT] = st.port_phy_pd[0];
        end
        REG_P2_BASIC: begin
          next_st.read_word[PHY_RESET_BIT] = st.port_phy_reset[1];
          next_st.read_word[PHY_POWER_DOWN_BIT] = st.port_phy_pd[1];
        end
        REG_VPHY_BASIC: begin
          next_st.read_word[PHY_RESET_BIT] = st.virtual_phy_reset;
        end
        REG_INT_STS: next_st.read_word[IRQ_W-1:0] = st.status;
        REG_INT_MASK: next_st.read_word[IRQ_W-1:0] = st.mask;
        REG_GPT_CFG: begin
          next_st.read_word[15:0] = st.gpt_reload;
          next_st.read_word[GPT_EN_BIT] = st.gpt_en;
        end
        REG_GPT_COUNT: next_st.read_word[15:0] = st.gpt_count;
        REG_FREE_COUNT: next_st.read_word = st.free_count;
        REG_LOADER_CMD: begin
          next_st.read_word[LOADER_RELOAD_BIT] = st.reload_cmd;
          next_st.read_word[LOADER_BUSY_BIT] = st.load_run;
        end
        default: next_st.read_word = '0;
      endcase
    end

    // Pin reset reinitialises all control state synchronously; the clock divider keeps running
    if (pin_reset) begin
      next_st = INIT;
    end

    next_st.irq_out = |(next_st.status & next_st.mask);
    next_st.wake_out =
      next_st.power_mgmt_control_reg[PMT_WAKE_OUT_EN_BIT]
      & |(next_st.status[IRQ_MAGIC:IRQ_WAKE_FRAME]
      & next_st.power_mgmt_control_reg[PMT_WAKE_EN_LSB+2:PMT_WAKE_EN_LSB]);
    next_st.power[0] = next_st.power_mgmt_control_reg[PMT_P1_PD_BIT]
      | next_st.port_phy_pd[0];
    next_st.power[1] = next_st.power_mgmt_control_reg[PMT_P1_EDPD_BIT];
    next_st.power[2] = next_st.power_mgmt_control_reg[PMT_P2_PD_BIT]
      | next_st.port_phy_pd[1];
    next_st.power[3] = next_st.power_mgmt_control_reg[PMT_P2_EDPD_BIT];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= INIT;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.read_word;
  assign irq = st.irq_out;
  assign loader_run = st.load_run;
  assign wake_event_output = st.wake_out;
  assign ref_tick = ref_strobe;
  assign digital_reset_n = dom_rst_n[DOM_DIGITAL];
  assign host_group_reset_n = dom_rst_n[DOM_HOST];
  assign port1_phy_reset_n = dom_rst_n[DOM_PORT1];
  assign port2_phy_reset_n = dom_rst_n[DOM_PORT2];
  assign virtual_phy_reset_n = dom_rst_n[DOM_VPHY];
  assign port1_power_down = st.power[0];
  assign port1_energy_detect_pd = st.power[1];
  assign port2_power_down = st.power[2];
  assign port2_energy_detect_pd = st.power[3];
endmodule : system_clock_reset_wake_control

// ===== hw/clk_rst_wake_pkg.sv
package clk_rst_wake_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_RESET_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_HW_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PMT_CTL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_P1_BASIC = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_P2_BASIC = 8'h10;
  localparam logic [ADDR_W-1:0] REG_VPHY_BASIC = 8'h14;
  localparam logic [ADDR_W-1:0] REG_INT_STS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_GPT_CFG = 8'h20;
  localparam logic [ADDR_W-1:0] REG_GPT_COUNT = 8'h24;
  localparam logic [ADDR_W-1:0] REG_FREE_COUNT = 8'h28;
  localparam logic [ADDR_W-1:0] REG_LOADER_CMD = 8'h2C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DIGITAL_BIT = 0;
  localparam int PORT1_PHY_BIT = 1;
  localparam int PORT2_PHY_BIT = 2;
  localparam int HOST_GROUP_BIT = 0;
  localparam int PMT_WAKE_OUT_EN_BIT = 0;
  localparam int PMT_WAKE_EN_LSB = 1;
  localparam int PMT_P1_PD_BIT = 4;
  localparam int PMT_P1_EDPD_BIT = 5;
  localparam int PMT_P2_PD_BIT = 6;
  localparam int PMT_P2_EDPD_BIT = 7;
  localparam int PMT_VPHY_RESET_BIT = 10;
  localparam int PHY_RESET_BIT = 15;
  localparam int PHY_POWER_DOWN_BIT = 11;
  localparam int GPT_EN_BIT = 16;
  localparam int LOADER_RELOAD_BIT = 0;
  localparam int LOADER_BUSY_BIT = 1;

  // Interrupt status layout
  localparam int IRQ_WAKE_FRAME = 0;
  localparam int IRQ_ENERGY = 1;
  localparam int IRQ_MAGIC = 2;
  localparam int IRQ_GPT = 3;
  localparam int IRQ_LOADER = 4;
  localparam int IRQ_W = 5;

  // Reset domains
  localparam int DOM_DIGITAL = 0;
  localparam int DOM_HOST = 1;
  localparam int DOM_PORT1 = 2;
  localparam int DOM_PORT2 = 3;
  localparam int DOM_VPHY = 4;
  localparam int DOM_N = 5;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [15:0] PMT_RESET = 16'h0000;
  localparam logic [15:0] GPT_RELOAD_RESET = 16'hFFFF;
  localparam int SYS_CLK_MHZ = 250;
  localparam int REF_CLK_MHZ = 25;
  localparam int REF_DIV = SYS_CLK_MHZ / REF_CLK_MHZ;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_CYCLES =
    (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GPT_TICK_NS = 1000;
  localparam int GPT_TICK_DIV = (GPT_TICK_NS * 1000) / CLK_PERIOD_PS;
endpackage : clk_rst_wake_pkg

// ===== hw/ref_clock_divider.sv
`timescale 1ns/1ps
module ref_clock_divider
  import clk_rst_wake_pkg::*;
#(
  parameter int REF_DIVIDE = REF_DIV,
  parameter int TICK_DIVIDE = GPT_TICK_DIV
) (
  input wire logic mclk,
  input wire logic reset_n,
  output logic ref_tick,
  output logic timer_tick
);
  localparam int AW = $clog2(REF_DIVIDE);
  localparam int BW = $clog2(TICK_DIVIDE);

  typedef struct packed {
    logic [AW-1:0] ref_cnt;
    logic [BW-1:0] tick_cnt;
    logic ref_pulse;
    logic tick_pulse;
  } div_state_type;

  div_state_type st;
  div_state_type next_st;

  // Reference rate and timer prescale as one-cycle strobes
  always_comb begin
    next_st = st;
    next_st.ref_pulse = (st.ref_cnt == AW'(REF_DIVIDE - 1));
    next_st.ref_cnt = next_st.ref_pulse ? '0 : st.ref_cnt + 1'b1;
    next_st.tick_pulse = (st.tick_cnt == BW'(TICK_DIVIDE - 1));
    next_st.tick_cnt = next_st.tick_pulse ? '0 : st.tick_cnt + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ref_tick = st.ref_pulse;
  assign timer_tick = st.tick_pulse;
endmodule : ref_clock_divider

// ===== hw/reset_domain_pulse.sv
`timescale 1ns/1ps
module reset_domain_pulse
  import clk_rst_wake_pkg::*;
#(
  parameter int CYCLES = RESET_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic hold,
  output logic domain_reset_n,
  output logic active,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic act;
    logic fin;
    logic rst_n;
  } pulse_state_type;

  // Power-on leaves the domain in reset for a full pulse
  localparam pulse_state_type INIT = '{count: '0, act: 1'b1,
    fin: 1'b0, rst_n: 1'b0};

  pulse_state_type st;
  pulse_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.fin = 1'b0;
    if (hold) begin
      next_st.act = 1'b1;
      next_st.count = '0;
    end else if (st.act) begin
      if (st.count == CW'(CYCLES - 1)) begin
        next_st.act = 1'b0;
        next_st.fin = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end else if (start && !st.fin) begin
      // Fin blocks a retrigger while the request bit is being cleared
      next_st.act = 1'b1;
      next_st.count = '0;
    end
    next_st.rst_n = !next_st.act;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= INIT;
    end else begin
      st <= next_st;
    end
  end

  assign domain_reset_n = st.rst_n;
  assign active = st.act;
  assign done = st.fin;
endmodule : reset_domain_pulse

// ===== hw/unused_marker.sv
`timescale 1ns/1ps

// ===== sim/system_clock_reset_wake_control_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reset domain, loader sequencing, reference tick and read data checks
// ----------------------------------------
module system_clock_reset_wake_control_assertions
  import clk_rst_wake_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic external_reset_pin_n,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic loader_done,
  input wire logic loader_run,
  input wire logic ref_tick,
  input wire logic digital_reset_n,
  input wire logic host_group_reset_n,
  input wire logic port1_phy_reset_n,
  input wire logic port2_phy_reset_n,
  input wire logic virtual_phy_reset_n
);
  logic [7:0] low_cnt;
  logic all_up;
  assign all_up = digital_reset_n & host_group_reset_n & port1_phy_reset_n
    & port2_phy_reset_n & virtual_phy_reset_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Saturates so a long pin reset cannot wrap it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 8'h00;
    end else if (digital_reset_n) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence tick_gap;
    !ref_tick [*8] ##1 !ref_tick;
  endsequence
  sequence all_held;
    !digital_reset_n && !host_group_reset_n && !port1_phy_reset_n
      && !port2_phy_reset_n && !virtual_phy_reset_n;
  endsequence
  a_ref_tick_period: assert property (
    ref_tick |=> tick_gap ##1 ref_tick)
    else $error("reference tick period wrong");
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_reset_min_len: assert property (
    $rose(digital_reset_n) |-> low_cnt >= 8'(RESET_CYCLES - 1))
    else $error("digital reset too short");
  a_pin_holds_all: assert property (!external_reset_pin_n |=> all_held)
    else $error("pin reset left a domain running");
  a_loader_start_clean: assert property ($rose(loader_run) |-> all_up)
    else $error("loader started during reset");
  a_loader_done_drop: assert property (
    loader_run && loader_done |=> !loader_run)
    else $error("loader kept running after done");
  a_loader_after_reset: assert property (
    $rose(digital_reset_n) |-> ##[0:4] loader_run)
    else $error("loader did not follow digital reset");
  a_digital_spares_phy: assert property (
    $fell(digital_reset_n) && port1_phy_reset_n && port2_phy_reset_n
      |=> port1_phy_reset_n && port2_phy_reset_n)
    else $error("digital reset hit a port phy");
  a_host_alone_reset: assert property (
    $fell(host_group_reset_n) && digital_reset_n |=> digital_reset_n [*4])
    else $error("host reset spread to digital domain");
endmodule : system_clock_reset_wake_control_assertions

bind system_clock_reset_wake_control
  system_clock_reset_wake_control_assertions chk_u (
  .mclk(mclk), .reset_n(reset_n),
  .external_reset_pin_n(external_reset_pin_n), .rd(rd), .rdata(rdata),
  .loader_done(loader_done), .loader_run(loader_run), .ref_tick(ref_tick),
  .digital_reset_n(digital_reset_n), .host_group_reset_n(host_group_reset_n),
  .port1_phy_reset_n(port1_phy_reset_n),
  .port2_phy_reset_n(port2_phy_reset_n),
  .virtual_phy_reset_n(virtual_phy_reset_n));

// ===== sim/system_clock_reset_wake_control_tb.sv
`timescale 1ns/1ps
module system_clock_reset_wake_control_tb;
  import clk_rst_wake_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_n = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic done_p = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [DATA_W-1:0] rdata, got, got2;
  logic [2:0] ev = 3'h0;
  logic irq, ld_run, wake, tick;
  logic [4:0] dom_n;
  logic [3:0] pd;
  int n_fail = 0;
  int tests_run = 0;
  int i, k;
  logic [ADDR_W-1:0] ra [6] = '{REG_PMT_CTL, REG_GPT_CFG, REG_GPT_COUNT,
    REG_RESET_CTRL, REG_INT_MASK, 8'hF0};
  logic [DATA_W-1:0] rv [6] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0,
    32'h0};
  logic [ADDR_W-1:0] sa [7] = '{REG_RESET_CTRL, REG_RESET_CTRL, REG_HW_CONFIG,
    REG_PMT_CTL, REG_P1_BASIC, REG_P2_BASIC, REG_VPHY_BASIC};
  logic [DATA_W-1:0] sd [7] = '{32'h2, 32'h4, 32'h1, 32'h400, 32'h8000,
    32'h8000, 32'h8000};
  logic [4:0] sm [7] = '{5'h04, 5'h08, 5'h02, 5'h10, 5'h04, 5'h08, 5'h10};

  always #2 mclk = ~mclk;

  system_clock_reset_wake_control dut_u (
    .mclk(mclk), .reset_n(reset_n), .external_reset_pin_n(pin_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .wake_frame_event(ev[0]), .energy_detect_event(ev[1]),
    .magic_packet_event(ev[2]), .loader_done(done_p),
    .loader_run(ld_run), .wake_event_output(wake), .ref_tick(tick),
    .digital_reset_n(dom_n[DOM_DIGITAL]),
    .host_group_reset_n(dom_n[DOM_HOST]),
    .port1_phy_reset_n(dom_n[DOM_PORT1]),
    .port2_phy_reset_n(dom_n[DOM_PORT2]),
    .virtual_phy_reset_n(dom_n[DOM_VPHY]),
    .port1_power_down(pd[0]), .port1_energy_detect_pd(pd[1]),
    .port2_power_down(pd[2]), .port2_energy_detect_pd(pd[3]));

  // ----------------------------------------
  // Bus and bookkeeping tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [DATA_W-1:0] g,
                       input logic [DATA_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : check

  task automatic timed_out();
    n_fail++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask : timed_out

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // Data is taken inside the single cycle it stands
  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask : rd_chk

  task automatic wait_dom();
    int j;
    for (j = 0; j < 200 && dom_n !== 5'h1F; j++) @(posedge mclk);
    if (dom_n !== 5'h1F) timed_out();
  endtask : wait_dom

  task automatic serve_ld();
    int j;
    for (j = 0; j < 100 && ld_run !== 1'b1; j++) @(posedge mclk);
    if (ld_run !== 1'b1) timed_out();
    @(posedge mclk);
    done_p <= 1'b1;
    @(posedge mclk);
    done_p <= 1'b0;
    cyc(2);
    check(32'(ld_run), 32'h0);
  endtask : serve_ld

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    check(32'(dom_n), 32'h0);
    reset_n <= 1'b1;
    wait_dom();
    serve_ld();
    rd_chk(REG_INT_STS, 32'h1 << IRQ_LOADER);
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    wr_reg(REG_INT_STS, 32'h1F);
    wr_reg(REG_RESET_CTRL, 32'h1);
    cyc(2);
    check(32'(dom_n), 32'h0C);
    rd_chk(REG_RESET_CTRL, 32'h1);
    wait_dom();
    rd_chk(REG_RESET_CTRL, 32'h0);
    serve_ld();
    for (i = 0; i < 7; i++) begin
      wr_reg(sa[i], sd[i]);
      cyc(2);
      check(32'(dom_n ^ 5'h1F), 32'(sm[i]));
      wait_dom();
      rd_chk(sa[i], 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(REG_PMT_CTL, 32'h10 << i);
      cyc(2);
      check(32'(pd), 32'h1 << i);
    end
    wr_reg(REG_PMT_CTL, 32'h0);
    wr_reg(REG_P1_BASIC, 32'h800);
    cyc(2);
    check(32'(pd), 32'h1);
    wr_reg(REG_P1_BASIC, 32'h0);
    wr_reg(REG_INT_STS, 32'h1F);
    // Event arrives while masked, then mask and global enable open
    for (i = 0; i < 3; i++) begin
      wr_reg(REG_INT_MASK, 32'h0);
      wr_reg(REG_PMT_CTL, 32'h2 << i);
      @(posedge mclk);
      ev <= 3'h1 << i;
      @(posedge mclk);
      ev <= 3'h0;
      cyc(2);
      check(32'({irq, wake}), 32'h0);
      wr_reg(REG_INT_MASK, 32'h1 << i);
      wr_reg(REG_PMT_CTL, (32'h2 << i) | 32'h1);
      cyc(2);
      check(32'({irq, wake}), 32'h3);
      rd_chk(REG_INT_STS, 32'h1 << i);
      wr_reg(REG_INT_STS, 32'h1 << i);
      cyc(2);
      check(32'({irq, wake}), 32'h0);
    end
    k = 0;
    repeat (100) begin
      cyc(1);
      if (tick === 1'b1) k++;
    end
    check(32'(k), 32'hA);
    rd_reg(REG_FREE_COUNT, got);
    repeat (98) @(posedge mclk);
    rd_reg(REG_FREE_COUNT, got2);
    check(got2 - got, 32'hA);
    // Four ticks of one microsecond each cannot wrap within 400 cycles
    wr_reg(REG_GPT_CFG, 32'h10003);
    rd_chk(REG_GPT_CFG, 32'h10003);
    cyc(400);
    rd_chk(REG_INT_STS, 32'h0);
    cyc(1000);
    rd_chk(REG_INT_STS, 32'h1 << IRQ_GPT);
    wr_reg(REG_GPT_CFG, 32'h0);
    wr_reg(REG_INT_STS, 32'h1F);
    wr_reg(REG_LOADER_CMD, 32'h1);
    rd_chk(REG_LOADER_CMD, 32'h3);
    serve_ld();
    rd_chk(REG_LOADER_CMD, 32'h0);
    rd_chk(REG_INT_STS, 32'h1 << IRQ_LOADER);
    wr_reg(REG_INT_MASK, 32'h1F);
    @(posedge mclk);
    pin_n <= 1'b0;
    cyc(3);
    check(32'(dom_n), 32'h0);
    @(posedge mclk);
    pin_n <= 1'b1;
    wait_dom();
    rd_chk(REG_INT_MASK, 32'h0);
    serve_ld();
    give_verdict();
  end
endmodule : system_clock_reset_wake_control_tb
